/* File: hdl/dcs_dot_sync.v */
// Dot clock divider, sync timing generator and output pin routing
//
// The address map and strobed register access were chosen for this implementation.
`timescale 1ns/1ps
`include "dcs_defs.vh"

module dcs_dot_sync #(
  parameter TW = 12
) (
  input wire clk_in, // System clock, also the internal display clock
  input wire rstn_in, // Synchronous reset, active low
  input wire [7:0] addr_in, // Register byte address
  input wire [31:0] wdata_in, // Register write data
  input wire wr_in, // Write strobe
  input wire rd_in, // Read strobe
  output reg [31:0] rdata_out, // Read data, cycle after the read strobe
  input wire ext_dot_clock_in, // External dot clock source
  input wire ext_hsync_in, // External horizontal sync for TV sync mode
  input wire ext_vsync_in, // External vertical sync for TV sync mode
  output reg dot_clock_out, // Dot clock pin
  output reg hsync_out, // Horizontal sync pin
  output reg vsync_out, // Vertical sync pin
  output reg odd_field_out, // Odd field or clamp pin
  output reg display_period_strobe_out // Display period pin
);

  // --------------------------------------------------------------------------
  // Configuration registers
  // --------------------------------------------------------------------------
  reg [1:0] sys_ctrl_reg;
  reg [7:0] sig_mode_reg;
  reg extended_divisor_enable_reg;
  reg [4:0] dot_divisor_select_reg;
  reg dot_clock_out_ctl_reg;
  reg dot_source_select_reg;
  reg [TW-1:0] hdisp_start_reg;
  reg [TW-1:0] hdisp_end_reg;
  reg [TW-1:0] hsync_width_reg;
  reg [TW-1:0] hscan_period_reg;
  reg [TW-1:0] vdisp_start_reg;
  reg [TW-1:0] vdisp_end_reg;
  reg [TW-1:0] vsync_position_reg;
  reg [TW-1:0] vscan_period_reg;

  // --------------------------------------------------------------------------
  // Datapath state
  // --------------------------------------------------------------------------
  reg ext_clk_q_reg;
  reg ext_clk_prev_reg;
  reg ext_hs_prev_reg;
  reg ext_vs_prev_reg;
  reg [4:0] div_cnt_reg;
  reg [TW-1:0] hcnt_reg;
  reg [TW-1:0] vcnt_reg;
  reg odd_field_flag_reg;

  wire run = sys_ctrl_reg[`DCS_SYS_RUN_BIT];
  wire tv_mode = sys_ctrl_reg[`DCS_SYS_TV_BIT];

  function [TW-1:0] fld;
    input [31:0] w;
    begin
      fld = w[TW-1:0];
    end
  endfunction

  function apply_pol;
    input active;
    input high_pol;
    begin
      apply_pol = high_pol ? active : ~active;
    end
  endfunction

  // --------------------------------------------------------------------------
  // Register writes
  // --------------------------------------------------------------------------
  wire [4:0] wr_div = wdata_in[`DCS_DIV_LSB+4:`DCS_DIV_LSB];

  always @(posedge clk_in) begin
    if (!rstn_in) begin
      sys_ctrl_reg <= `DCS_RST_SYS_CTRL;
      sig_mode_reg <= `DCS_RST_SIG_MODE;
      extended_divisor_enable_reg <= 1'b0;
      dot_divisor_select_reg <= `DCS_RST_DIV;
      dot_clock_out_ctl_reg <= 1'b0;
      dot_source_select_reg <= 1'b0;
      hdisp_start_reg <= `DCS_RST_TIMING;
      hdisp_end_reg <= `DCS_RST_TIMING;
      hsync_width_reg <= `DCS_RST_TIMING;
      hscan_period_reg <= `DCS_RST_TIMING;
      vdisp_start_reg <= `DCS_RST_TIMING;
      vdisp_end_reg <= `DCS_RST_TIMING;
      vsync_position_reg <= `DCS_RST_TIMING;
      vscan_period_reg <= `DCS_RST_TIMING;
    end else if (wr_in) begin
      if (addr_in == `DCS_OFF_SYS_CTRL) begin
        sys_ctrl_reg <= wdata_in[1:0];
      end else if (addr_in == `DCS_OFF_SIG_MODE) begin
        sig_mode_reg <= wdata_in[7:0];
      end else if (addr_in == `DCS_OFF_EXT_FUNC) begin
        extended_divisor_enable_reg <= wdata_in[`DCS_EXT_EXTENDED_DIVISOR_ENABLE_BIT];
      end else if (addr_in == `DCS_OFF_EXT_SYNC) begin
        // Large divisor refused unless extended enable is already set
        if (extended_divisor_enable_reg || wr_div <= `DCS_DIV_STD_MAX) begin
          dot_divisor_select_reg <= wr_div;
        end
        dot_clock_out_ctl_reg <= wdata_in[`DCS_OUT_EN_BIT];
        dot_source_select_reg <= wdata_in[`DCS_SRC_BIT];
      end else if (addr_in == `DCS_OFF_HDS) begin
        hdisp_start_reg <= fld(wdata_in);
      end else if (addr_in == `DCS_OFF_HDE) begin
        hdisp_end_reg <= fld(wdata_in);
      end else if (addr_in == `DCS_OFF_HSW) begin
        hsync_width_reg <= fld(wdata_in);
      end else if (addr_in == `DCS_OFF_HC) begin
        hscan_period_reg <= fld(wdata_in);
      end else if (addr_in == `DCS_OFF_VDS) begin
        vdisp_start_reg <= fld(wdata_in);
      end else if (addr_in == `DCS_OFF_VDE) begin
        vdisp_end_reg <= fld(wdata_in);
      end else if (addr_in == `DCS_OFF_VSP) begin
        vsync_position_reg <= fld(wdata_in);
      end else if (addr_in == `DCS_OFF_VC) begin
        vscan_period_reg <= fld(wdata_in);
      end
    end
  end

  // --------------------------------------------------------------------------
  // Source selection and divider
  // --------------------------------------------------------------------------
  always @(posedge clk_in) begin
    if (!rstn_in) begin
      ext_clk_q_reg <= 1'b0;
      ext_clk_prev_reg <= 1'b0;
      ext_hs_prev_reg <= 1'b0;
      ext_vs_prev_reg <= 1'b0;
    end else begin
      ext_clk_q_reg <= ext_dot_clock_in;
      ext_clk_prev_reg <= ext_clk_q_reg;
      ext_hs_prev_reg <= ext_hsync_in;
      ext_vs_prev_reg <= ext_vsync_in;
    end
  end

  // Internal source ticks every clock; external one on each sampled rising edge
  wire src_tick = dot_source_select_reg ? 1'b1 : (ext_clk_q_reg & ~ext_clk_prev_reg);

  // Clearing extended enable later drops divisor bit 4 and uses bits 3:0 only, rather than stalling
  wire [4:0] div_max = extended_divisor_enable_reg ? dot_divisor_select_reg :
                       {1'b0, dot_divisor_select_reg[3:0]};
  wire [4:0] div_half = {1'b0, div_max[4:1]};
  wire dot_tick = src_tick && (div_cnt_reg == div_max);

  always @(posedge clk_in) begin
    if (!rstn_in) begin
      div_cnt_reg <= 5'h00;
    end else if (src_tick) begin
      if (div_cnt_reg >= div_max) begin
        div_cnt_reg <= 5'h00;
      end else begin
        div_cnt_reg <= div_cnt_reg + 5'h01;
      end
    end
  end

  // --------------------------------------------------------------------------
  // Dot and line counters
  // --------------------------------------------------------------------------
  wire ext_hs_edge = ext_hsync_in & ~ext_hs_prev_reg;
  wire ext_vs_edge = ext_vsync_in & ~ext_vs_prev_reg;
  wire line_end = (hcnt_reg >= hscan_period_reg);
  wire frame_end = line_end && (vcnt_reg >= vscan_period_reg);

  always @(posedge clk_in) begin
    if (!rstn_in || !run) begin
      hcnt_reg <= {TW{1'b0}};
      vcnt_reg <= {TW{1'b0}};
      odd_field_flag_reg <= 1'b0;
    end else if (tv_mode && ext_vs_edge) begin
      // TV sync: frame and line restart on the external edges
      hcnt_reg <= {TW{1'b0}};
      vcnt_reg <= {TW{1'b0}};
      odd_field_flag_reg <= ~odd_field_flag_reg;
    end else if (tv_mode && ext_hs_edge) begin
      hcnt_reg <= {TW{1'b0}};
      vcnt_reg <= vcnt_reg + {{(TW-1){1'b0}}, 1'b1};
    end else if (dot_tick) begin
      if (!line_end) begin
        hcnt_reg <= hcnt_reg + {{(TW-1){1'b0}}, 1'b1};
      end else begin
        hcnt_reg <= {TW{1'b0}};
        if (frame_end && !tv_mode) begin
          vcnt_reg <= {TW{1'b0}};
          odd_field_flag_reg <= ~odd_field_flag_reg;
        end else begin
          vcnt_reg <= vcnt_reg + {{(TW-1){1'b0}}, 1'b1};
        end
      end
    end
  end

  // --------------------------------------------------------------------------
  // Sync and strobe generation
  // --------------------------------------------------------------------------
  wire hs_act = run && (hcnt_reg <= hsync_width_reg);
  wire vs_act = run && (vcnt_reg >= vsync_position_reg);
  wire cs_act = hs_act | vs_act;
  wire h_area = (hcnt_reg >= hdisp_start_reg) && (hcnt_reg < hdisp_end_reg);
  wire v_area = (vcnt_reg >= vdisp_start_reg) && (vcnt_reg < vdisp_end_reg);
  // Strobe forced off when stopped so no pixel is shown out of the area
  wire display_period_strobe_act = run && h_area && v_area;
  wire clamp_act = run && (hcnt_reg > hsync_width_reg) && (hcnt_reg < hdisp_start_reg);

  wire [1:0] dsel = sig_mode_reg[`DCS_SIG_DSEL_LSB+1:`DCS_SIG_DSEL_LSB];
  wire dpol = sig_mode_reg[`DCS_SIG_DPOL_BIT];
  wire hpol = sig_mode_reg[`DCS_SIG_HPOL_BIT];
  wire vpol = sig_mode_reg[`DCS_SIG_VPOL_BIT];

  reg display_period_strobe_next;
  reg hsync_next;
  reg vsync_next;
  reg odd_next;
  reg dot_next;

  always @* begin
    if (dsel == `DCS_DSEL_COMPOSITE_SYNC) begin
      display_period_strobe_next = apply_pol(cs_act, hpol);
    end else if (dsel == `DCS_DSEL_DE) begin
      // Data enable is always active high for encoder inputs
      display_period_strobe_next = display_period_strobe_act;
    end else begin
      display_period_strobe_next = apply_pol(display_period_strobe_act, dpol);
    end
    if (sig_mode_reg[`DCS_SIG_HSEL_BIT]) begin
      hsync_next = apply_pol(cs_act, hpol);
    end else begin
      hsync_next = apply_pol(hs_act, hpol);
    end
    if (sig_mode_reg[`DCS_SIG_VSEL_BIT]) begin
      vsync_next = apply_pol(cs_act, vpol);
    end else begin
      vsync_next = apply_pol(vs_act, vpol);
    end
    if (sig_mode_reg[`DCS_SIG_OSEL_BIT]) begin
      odd_next = clamp_act;
    end else begin
      odd_next = odd_field_flag_reg;
    end
    // Divide by one on the internal clock cannot toggle from flops: held high
    if (!dot_clock_out_ctl_reg) begin
      dot_next = 1'b0;
    end else if (div_max == 5'h00 && !dot_source_select_reg) begin
      dot_next = ext_clk_q_reg;
    end else begin
      dot_next = (div_cnt_reg <= div_half);
    end
  end

  // --------------------------------------------------------------------------
  // Registered pins and read data
  // --------------------------------------------------------------------------
  always @(posedge clk_in) begin
    if (!rstn_in) begin
      dot_clock_out <= 1'b0;
      hsync_out <= 1'b1;
      vsync_out <= 1'b1;
      odd_field_out <= 1'b0;
      display_period_strobe_out <= 1'b0;
    end else begin
      dot_clock_out <= dot_next;
      hsync_out <= hsync_next;
      vsync_out <= vsync_next;
      odd_field_out <= odd_next;
      display_period_strobe_out <= display_period_strobe_next;
    end
  end

  always @(posedge clk_in) begin
    if (!rstn_in) begin
      rdata_out <= 32'h00000000;
    end else if (!rd_in) begin
      rdata_out <= 32'h00000000;
    end else if (addr_in == `DCS_OFF_SYS_CTRL) begin
      rdata_out <= {30'h00000000, sys_ctrl_reg};
    end else if (addr_in == `DCS_OFF_SIG_MODE) begin
      rdata_out <= {24'h000000, sig_mode_reg};
    end else if (addr_in == `DCS_OFF_EXT_FUNC) begin
      rdata_out <= {31'h00000000, extended_divisor_enable_reg};
    end else if (addr_in == `DCS_OFF_EXT_SYNC) begin
      rdata_out <= {19'h00000, dot_source_select_reg, 3'h0, dot_clock_out_ctl_reg,
                    3'h0, dot_divisor_select_reg};
    end else if (addr_in == `DCS_OFF_HDS) begin
      rdata_out <= {{(32-TW){1'b0}}, hdisp_start_reg};
    end else if (addr_in == `DCS_OFF_HDE) begin
      rdata_out <= {{(32-TW){1'b0}}, hdisp_end_reg};
    end else if (addr_in == `DCS_OFF_HSW) begin
      rdata_out <= {{(32-TW){1'b0}}, hsync_width_reg};
    end else if (addr_in == `DCS_OFF_HC) begin
      rdata_out <= {{(32-TW){1'b0}}, hscan_period_reg};
    end else if (addr_in == `DCS_OFF_VDS) begin
      rdata_out <= {{(32-TW){1'b0}}, vdisp_start_reg};
    end else if (addr_in == `DCS_OFF_VDE) begin
      rdata_out <= {{(32-TW){1'b0}}, vdisp_end_reg};
    end else if (addr_in == `DCS_OFF_VSP) begin
      rdata_out <= {{(32-TW){1'b0}}, vsync_position_reg};
    end else if (addr_in == `DCS_OFF_VC) begin
      rdata_out <= {{(32-TW){1'b0}}, vscan_period_reg};
    end else if (addr_in == `DCS_OFF_STATUS) begin
      rdata_out <= {14'h0000, display_period_strobe_act, odd_field_flag_reg, {(16-TW){1'b0}}, vcnt_reg};
    end else begin
      rdata_out <= 32'h00000000;
    end
  end

endmodule

/* File: shared/dcs_defs.vh */
// Register map, field positions, field codes and reset values of the dot clock and sync block
`ifndef DCS_DEFS_VH
`define DCS_DEFS_VH

// ----------------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------------
`define DCS_OFF_SYS_CTRL 8'h00
`define DCS_OFF_SIG_MODE 8'h04
`define DCS_OFF_EXT_FUNC 8'h08
`define DCS_OFF_EXT_SYNC 8'h0C
`define DCS_OFF_HDS 8'h10
`define DCS_OFF_HDE 8'h14
`define DCS_OFF_HSW 8'h18
`define DCS_OFF_HC 8'h1C
`define DCS_OFF_VDS 8'h20
`define DCS_OFF_VDE 8'h24
`define DCS_OFF_VSP 8'h28
`define DCS_OFF_VC 8'h2C
`define DCS_OFF_STATUS 8'h30

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define DCS_SYS_RUN_BIT 0
`define DCS_SYS_TV_BIT 1
`define DCS_SIG_VSEL_BIT 0
`define DCS_SIG_OSEL_BIT 1
`define DCS_SIG_DSEL_LSB 2
`define DCS_SIG_HSEL_BIT 4
`define DCS_SIG_DPOL_BIT 5
`define DCS_SIG_HPOL_BIT 6
`define DCS_SIG_VPOL_BIT 7
`define DCS_EXT_EXTENDED_DIVISOR_ENABLE_BIT 0
`define DCS_DIV_LSB 0
`define DCS_OUT_EN_BIT 8
`define DCS_SRC_BIT 12
`define DCS_STAT_ODD_BIT 16
`define DCS_STAT_DISPLAY_PERIOD_STROBE_BIT 17

// ----------------------------------------------------------------------------
// Field codes and reset values
// ----------------------------------------------------------------------------
`define DCS_DSEL_DISPLAY_PERIOD_STROBE 2'h0
`define DCS_DSEL_COMPOSITE_SYNC 2'h1
`define DCS_DSEL_DE 2'h2
`define DCS_DIV_STD_MAX 5'h0F
`define DCS_RST_SYS_CTRL 2'h0
`define DCS_RST_SIG_MODE 8'h20
`define DCS_RST_DIV 5'h00
`define DCS_RST_TIMING 12'h000

`endif

/* File: verif/dcs_dot_sync_checker.sv */
// Assertions on the dot clock, sync pins and register port
`timescale 1ns/1ps
module dcs_dot_sync_checker #(
  parameter TW = 12
) (
  input wire clk_in, // Clock
  input wire rstn_in, // Reset
  input wire [7:0] addr_in, // Address
  input wire [31:0] wdata_in, // Write data
  input wire wr_in, // Write
  input wire rd_in, // Read
  input wire [31:0] rdata_out, // Read data
  input wire ext_dot_clock_in, // Ext dot clock
  input wire ext_hsync_in, // Ext hsync
  input wire ext_vsync_in, // Ext vsync
  input wire dot_clock_out, // Dot pin
  input wire hsync_out, // Hsync pin
  input wire vsync_out, // Vsync pin
  input wire odd_field_out, // Odd pin
  input wire display_period_strobe_out // Display_period_strobe pin
);
  // ------------------------------
  // Shadow of the written setup
  // ------------------------------
  reg [12:0] esc_reg;
  reg [7:0] sig_reg;
  reg ext_reg;
  reg [1:0] sys_reg;
  reg [TW-1:0] hsw_reg;
  reg [TW-1:0] hc_reg;
  reg [6:0] stab_reg;
  reg [31:0] dcnt_reg;
  reg [31:0] hlen_reg;
  reg [31:0] hper_reg;
  wire hs_act = hsync_out == sig_reg[6];
  wire vs_act = vsync_out == sig_reg[7];
  wire [1:0] dsel = sig_reg[3:2];
  wire display_period_strobe_act = (dsel == 2'h2) ? display_period_strobe_out : display_period_strobe_out == sig_reg[dsel == 2'h1 ? 6 : 5];
  wire [4:0] eff = (ext_reg || !esc_reg[4]) ? esc_reg[4:0] : {1'b0, esc_reg[3:0]};
  wire [31:0] div_w = eff + 32'h1;
  wire [31:0] hw_w = (hsw_reg + 32'h1) * div_w;
  wire [31:0] hp_w = (hc_reg + 32'h1) * div_w;
  // Pins lag the registers, so checks wait for a quiet spell after any write
  always @(posedge clk_in) begin
    stab_reg <= (!rstn_in || wr_in) ? 7'h00 : stab_reg + {6'h00, stab_reg != 7'h7F};
    dcnt_reg <= $rose(dot_clock_out) ? 32'h1 : dcnt_reg + 32'h1;
    hlen_reg <= hs_act ? hlen_reg + 32'h1 : 32'h0;
    hper_reg <= $rose(hs_act) ? 32'h1 : hper_reg + 32'h1;
    if (!rstn_in) begin
      esc_reg <= 13'h0000;
      sig_reg <= 8'h20;
      ext_reg <= 1'b0;
      sys_reg <= 2'h0;
      hsw_reg <= {TW{1'b0}};
      hc_reg <= {TW{1'b0}};
    end else if (wr_in) begin
      case (addr_in)
        8'h00: sys_reg <= wdata_in[1:0];
        8'h04: sig_reg <= wdata_in[7:0];
        8'h08: ext_reg <= wdata_in[0];
        8'h18: hsw_reg <= wdata_in[TW-1:0];
        8'h1C: hc_reg <= wdata_in[TW-1:0];
        8'h0C: begin
          esc_reg[12:5] <= wdata_in[12:5];
          if (ext_reg || !wdata_in[4]) esc_reg[4:0] <= wdata_in[4:0];
        end
        default: ;
      endcase
    end
  end
  // ------------------------------
  // Properties
  // ------------------------------
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rstn_in);
  AST_RESET: assert property (disable iff (1'b0) !rstn_in |=>
    !dot_clock_out && hsync_out && vsync_out && !display_period_strobe_out && !odd_field_out && rdata_out == 0
  ) else $error("pins not idle after reset");
  AST_DOT_OFF: assert property (stab_reg > 7'h03 && !esc_reg[8] |-> !dot_clock_out)
    else $error("dot clock driven while disabled");
  AST_DOT_PERIOD: assert property (
    stab_reg == 7'h7F && esc_reg[12] && $rose(dot_clock_out) |-> dcnt_reg == div_w
  ) else $error("dot clock period wrong");
  AST_EXT_HOLD: assert property (
    (!esc_reg[12] && stab_reg > 7'h08 && !ext_dot_clock_in)[*8] |-> $stable(dot_clock_out)
  ) else $error("dot clock moves without external edges");
  AST_IDLE_LEVEL: assert property (
    stab_reg > 7'h03 && !sys_reg[0] |-> !hs_act && !vs_act && !display_period_strobe_act && !odd_field_out
  ) else $error("pins active while stopped");
  AST_HS_WIDTH: assert property (
    stab_reg == 7'h7F && sys_reg == 2'h1 && !sig_reg[4] && $fell(hs_act) |-> hlen_reg == hw_w
  ) else $error("hsync width wrong");
  AST_HS_PERIOD: assert property (
    stab_reg == 7'h7F && sys_reg == 2'h1 && !sig_reg[4] && $rose(hs_act) |-> hper_reg == hp_w
  ) else $error("line period wrong");
  AST_VS_COMPOSITE_SYNC: assert property (
    stab_reg > 7'h03 && sys_reg[0] && sig_reg[0] && hs_act |-> vs_act
  ) else $error("composite sync missing on vsync pin");
  AST_HS_COMPOSITE_SYNC: assert property (
    stab_reg > 7'h03 && sys_reg[0] && sig_reg[4] && !sig_reg[0] && vs_act |-> hs_act
  ) else $error("composite sync missing on hsync pin");
  AST_CLAMP: assert property (
    stab_reg > 7'h03 && sys_reg[0] && sig_reg[1] && !sig_reg[4] && odd_field_out |-> !hs_act
  ) else $error("clamp overlaps hsync");
  AST_DISPLAY_PERIOD_STROBE_BLANK: assert property (
    stab_reg > 7'h03 && sys_reg[0] && sig_reg[3:2] != 2'h1 && !sig_reg[0] && display_period_strobe_act
    |-> !hs_act && !vs_act
  ) else $error("display active during sync");
  COV_DOT: cover property (stab_reg == 7'h7F && $rose(dot_clock_out));
  COV_TV: cover property (sys_reg == 2'h3 && $rose(hs_act));
  COV_CLAMP: cover property (sig_reg[1] && odd_field_out);
endmodule

bind dcs_dot_sync dcs_dot_sync_checker #(.TW(TW)) u_checker (
  .clk_in(clk_in), .rstn_in(rstn_in), .addr_in(addr_in), .wdata_in(wdata_in),
  .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out), .ext_dot_clock_in(ext_dot_clock_in),
  .ext_hsync_in(ext_hsync_in), .ext_vsync_in(ext_vsync_in), .dot_clock_out(dot_clock_out),
  .hsync_out(hsync_out), .vsync_out(vsync_out), .odd_field_out(odd_field_out),
  .display_period_strobe_out(display_period_strobe_out)
);

/* File: verif/dcs_dot_sync_test.sv */
// Self-checking bench for the dot clock and sync block
`timescale 1ns/1ps
module dcs_dot_sync_test;
  reg clk_in = 1'b0;
  reg rstn_in = 1'b0;
  reg [7:0] addr_in = 8'h00;
  reg [31:0] wdata_in = 32'h0;
  reg wr_in = 1'b0;
  reg rd_in = 1'b0;
  reg ext_hsync_in = 1'b0;
  reg ext_vsync_in = 1'b0;
  reg ext_en = 1'b0;
  reg rd_seen = 1'b0;
  wire [31:0] rdata_out;
  wire ext_dot_clock_in, dot_clock_out, hsync_out, vsync_out, odd_field_out, display_period_strobe_out;
  wire [63:0] hi_w;
  wire [63:0] per_w;
  int miscompares = 0;
  int tests_run = 0;
  int cycles = 0;
  int f;
  logic [31:0] v;
  logic [31:0] exp_q[$];
  int div_tab[5] = '{0, 1, 3, 15, 31};
  int tm_tab[8] = '{4, 8, 2, 9, 1, 3, 4, 5};
  logic [31:0] sig_tab[4] = '{32'h71, 32'h86, 32'h90, 32'h28};
  dcs_dot_sync #(.TW(12)) uut (.clk_in(clk_in), .rstn_in(rstn_in), .addr_in(addr_in),
    .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
    .ext_dot_clock_in(ext_dot_clock_in), .ext_hsync_in(ext_hsync_in),
    .ext_vsync_in(ext_vsync_in), .dot_clock_out(dot_clock_out), .hsync_out(hsync_out),
    .vsync_out(vsync_out), .odd_field_out(odd_field_out), .display_period_strobe_out(display_period_strobe_out));
  dcs_panel_model u_panel (.clk_in(clk_in), .ext_clk_en_in(ext_en),
    .pins_in({display_period_strobe_out, vsync_out, hsync_out, dot_clock_out}),
    .ext_dot_clock_out(ext_dot_clock_in), .hi_out(hi_w), .per_out(per_w));
  // ------------------------------
  // Helpers
  // ------------------------------
  always #50 clk_in = !clk_in;
  task check(input [31:0] seen, input [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask
  // Reads leave the expected word for the watcher below
  task bus(input bit w, input [7:0] a, input [31:0] d);
    addr_in <= a;
    wdata_in <= d;
    wr_in <= w;
    rd_in <= !w;
    if (!w) exp_q.push_back(d);
    @(posedge clk_in);
  endtask
  task idle(input int n);
    wr_in <= 1'b0;
    rd_in <= 1'b0;
    repeat (n) @(posedge clk_in);
  endtask
  task done(input string n);
    $display("test %s finished", n);
  endtask
  task end_of_test;
    $display("compares %0d, mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  always @(posedge clk_in) begin
    rd_seen <= rd_in;
    if (rd_seen) check(rdata_out, exp_q.pop_front());
  end
  always @(posedge clk_in) begin
    cycles <= cycles + 1;
    if (cycles == 6000) begin
      miscompares++;
      end_of_test();
    end
  end
  // ------------------------------
  // Main sequence
  // ------------------------------
  initial begin
    void'($urandom(90035));
    repeat (8) @(posedge clk_in);
    rstn_in <= 1'b1;
    check({hsync_out, vsync_out, dot_clock_out, display_period_strobe_out, odd_field_out}, 32'h18);
    for (int i = 0; i < 14; i++) bus(1'b0, 8'(4 * i), (i == 1) ? 32'h20 : 32'h0);
    done("reset");
    for (int i = 0; i < 8; i++) begin
      v = $urandom;
      bus(1'b1, 8'h10 + 8'(4 * i), v);
      bus(1'b0, 8'h10 + 8'(4 * i), v & 32'hFFF);
    end
    v = $urandom;
    bus(1'b1, 8'h04, v);
    bus(1'b0, 8'h04, v & 32'hFF);
    bus(1'b1, 8'h40, v);
    bus(1'b1, 8'h30, v);
    bus(1'b0, 8'h40, 32'h0);
    bus(1'b0, 8'h30, 32'h0);
    bus(1'b1, 8'h08, 32'h0);
    bus(1'b1, 8'h0C, 32'h1003);
    bus(1'b1, 8'h0C, 32'h0114);
    bus(1'b0, 8'h0C, 32'h0103);
    bus(1'b1, 8'h0C, 32'h100F);
    bus(1'b0, 8'h0C, 32'h100F);
    bus(1'b1, 8'h08, 32'h1);
    bus(1'b1, 8'h0C, 32'h0114);
    bus(1'b0, 8'h0C, 32'h0114);
    idle(2);
    done("registers");
    foreach (div_tab[k]) begin
      f = div_tab[k];
      bus(1'b1, 8'h0C, 32'h1100 | f);
      idle(80);
      if (f == 0) check(dot_clock_out, 1);
      else check(per_w[15:0], f + 1);
      if (f != 0) check(hi_w[15:0], f / 2 + 1);
    end
    bus(1'b1, 8'h0C, 32'h1003);
    for (int i = 0; i < 6; i++) begin
      idle(1);
      if (i > 1) check(dot_clock_out, 0);
    end
    ext_en <= 1'b1;
    bus(1'b1, 8'h0C, 32'h0101);
    idle(100);
    check(per_w[15:0], 16);
    ext_en <= 1'b0;
    // Quiet external source lets the hold assertion see a still dot clock
    idle(20);
    done("dot clock");
    foreach (tm_tab[k]) bus(1'b1, 8'h10 + 8'(4 * k), tm_tab[k]);
    bus(1'b1, 8'h0C, 32'h1101);
    for (int p = 0; p < 2; p++) begin
      bus(1'b1, 8'h04, p ? 32'hE0 : 32'h20);
      bus(1'b1, 8'h00, 32'h1);
      idle(300);
      check(per_w[31:16], 20);
      check(hi_w[31:16], p ? 6 : 14);
      check(per_w[47:32], 120);
      check(hi_w[47:32], p ? 40 : 80);
      check(hi_w[63:48], 8);
    end
    done("master timing");
    foreach (sig_tab[k]) begin
      bus(1'b1, 8'h04, sig_tab[k]);
      idle(150);
    end
    check(hi_w[63:48], 8);
    done("routing");
    bus(1'b1, 8'h1C, 32'h3C);
    bus(1'b1, 8'h00, 32'h3);
    ext_vsync_in <= 1'b1;
    idle(1);
    ext_vsync_in <= 1'b0;
    for (int i = 0; i < 8; i++) begin
      ext_hsync_in <= 1'b1;
      idle(1);
      ext_hsync_in <= 1'b0;
      idle(29);
    end
    check(per_w[31:16], 30);
    done("tv sync");
    end_of_test();
  end
endmodule

/* File: verif/dcs_panel_model.sv */
// Panel side model: external dot clock source and pulse meters on the pins
`timescale 1ns/1ps
module dcs_pulse_meter (
  input wire clk_in, // Clock
  input wire sig_in, // Watched pin
  output reg [15:0] hi_len_out = 16'h0000, // Last high run
  output reg [15:0] period_out = 16'h0000 // Last rise to rise
);
  reg [15:0] hi_reg = 16'h0000;
  reg [15:0] per_reg = 16'h0000;
  reg last_reg = 1'b0;
  always @(posedge clk_in) begin
    last_reg <= sig_in;
    hi_reg <= sig_in ? hi_reg + 16'h0001 : 16'h0000;
    per_reg <= (sig_in && !last_reg) ? 16'h0001 : per_reg + 16'h0001;
    if (!sig_in && last_reg) hi_len_out <= hi_reg;
    if (sig_in && !last_reg) period_out <= per_reg;
  end
endmodule

module dcs_panel_model (
  input wire clk_in, // Clock
  input wire ext_clk_en_in, // Run external dot clock
  input wire [3:0] pins_in, // Display_period_strobe, vsync, hsync, dot
  output reg ext_dot_clock_out = 1'b0, // Eight clocks a period
  output wire [63:0] hi_out, // High runs per pin
  output wire [63:0] per_out // Periods per pin
);
  reg [1:0] ph_reg = 2'h0;
  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1) begin : g_meter
      dcs_pulse_meter u_meter (.clk_in(clk_in), .sig_in(pins_in[g]),
        .hi_len_out(hi_out[16*g+:16]), .period_out(per_out[16*g+:16]));
    end
  endgenerate
  // Held low when off, so a stale level never looks like a clock
  always @(posedge clk_in) begin
    ph_reg <= ph_reg + 2'h1;
    if (!ext_clk_en_in) ext_dot_clock_out <= 1'b0;
    else if (ph_reg == 2'h3) ext_dot_clock_out <= !ext_dot_clock_out;
  end
endmodule
